// ==== design/rdm_pkg.sv ====
// Purpose: shared constants and carrier types of the relay driver mode
//          controller.
// Assumes: eight output channels and two direct input pins.
// Notes:   mode field codes other than limp home are local choices.
package rdm_pkg;

    // ************************************************************
    // sizes
    // ************************************************************
    localparam int NUM_CH = 8;
    localparam int NUM_IN = 2;

    // ************************************************************
    // mode field codes
    // ************************************************************
    localparam logic [1:0] MODE_IDLE   = 2'h0;
    localparam logic [1:0] MODE_LIMP   = 2'h1;
    localparam logic [1:0] MODE_ACTIVE = 2'h2;
    localparam logic [1:0] MODE_SLEEP  = 2'h3;

    // ************************************************************
    // channel masks and reset values
    // ************************************************************
    localparam logic [NUM_CH-1:0] CH_NONE   = 8'h00;
    localparam logic [NUM_CH-1:0] LIMP_MASK = 8'h0C;
    localparam logic [NUM_CH-1:0] MAP_A_RST = 8'h04;
    localparam logic [NUM_CH-1:0] MAP_B_RST = 8'h08;

    typedef enum logic [1:0] {
        ST_SLEEP,
        ST_IDLE,
        ST_ACTIVE,
        ST_LIMP
    } rdm_state_t;

    // supply comparator levels, all asynchronous to the clock
    typedef struct packed {
        logic vdd_ok;         // vdd present and above undervoltage
        logic vdd_in_lop;     // vdd inside the low operating range
        logic vs_below_uv;    // vs under its undervoltage threshold
        logic vs_above_op;    // vs above its operating threshold
    } rdm_supply_t;

    // programmable configuration
    typedef struct packed {
        logic [NUM_CH-1:0] channel_switch_bits;
        logic              stay_active_bit;
        logic              pwm_generator_select_a;
        logic              pwm_generator_select_b;
        logic [NUM_CH-1:0] input_map_a;
        logic [NUM_CH-1:0] input_map_b;
        logic              openload_on_enable;
        logic              openload_off_enable;
    } rdm_cfg_t;

    // one register write as delivered by the link at frame end
    typedef struct packed {
        rdm_cfg_t cfg;
        logic     soft_reset_bit;
    } rdm_write_t;

    // kind of a finished frame
    typedef struct packed {
        logic is_write;
        logic is_diag_read;
        logic is_bad;
    } rdm_frame_t;

    localparam rdm_cfg_t CFG_RESET = '{
        channel_switch_bits    : CH_NONE,
        stay_active_bit        : 1'b0,
        pwm_generator_select_a : 1'b0,
        pwm_generator_select_b : 1'b0,
        input_map_a            : MAP_A_RST,
        input_map_b            : MAP_B_RST,
        openload_on_enable     : 1'b0,
        openload_off_enable    : 1'b0
    };

    localparam rdm_write_t WRITE_RESET = '{cfg: CFG_RESET,
                                           soft_reset_bit: 1'b0};

endpackage

// ==== design/rdm_mode_controller.sv ====
// Purpose: operating mode controller of an SPI relay driver: chooses
//          sleep, idle, active or limp home, applies register resets,
//          keeps supply flags and drives the channel enables.
// Assumes: link logic delivers each finished frame with a one-cycle
//          pulse on the link clock and holds nothing itself.
// Notes:   clock_enable freezes the system domain only; the link side
//          capture keeps running on its own clock.
`timescale 1ns/1ps

// Summary of operation
// [RULE_01] four modes chosen from pins and control bits
// [RULE_02] turn-on request enters active or limp home
// [RULE_03] sleep: channels off, registers held reset
// [RULE_04] idle: channels off, diagnosis off, registers live
// [RULE_05] idle keeps channel error bits
// [RULE_06] wake high plus input or switch: active
// [RULE_07] stay bit clear, all low: back to idle
// [RULE_08] stay bit set holds active mode
// [RULE_09] vdd undervoltage, inputs low: active to idle
// [RULE_10] input high enters active despite empty maps
// [RULE_11] wake low plus input: limp home, channel on
// [RULE_12] limp home: reads answered, writes ignored
// [RULE_13] limp home: supply flags one, mode 01
// [RULE_14] first frame in limp home flags error
// [RULE_15] limp home: open-load enables forced zero
// [RULE_16] limp home: other registers held default
// [RULE_17] limp home: only channels two, three on
// [RULE_18] host avoids frames during limp transitions
// [RULE_19] vdd low, wake low, soft reset: registers reset
// [RULE_20] soft reset keeps errors, clears supply flags
// [RULE_21] register reset: unpinned channels off, maps default
// [RULE_22] vs undervoltage flag set, cleared at readout
// [RULE_23] power-on needs supply plus input or wake
// [RULE_24] vdd low-power flag set, cleared at readout
// [RULE_25] pins synchronised before mode decisions
module rdm_mode_controller (
    input  wire logic                        clock,
    input  wire logic                        rst,
    input  wire logic                        clock_enable,
    input  wire logic                        wake_pin,
    input  wire logic [rdm_pkg::NUM_IN-1:0]  direct_input_pins,
    input  wire rdm_pkg::rdm_supply_t        supply_levels,
    input  wire logic [rdm_pkg::NUM_CH-1:0]  channel_fault,
    input  wire logic                        link_clock,
    input  wire logic                        frame_end,
    input  wire rdm_pkg::rdm_frame_t         frame_kind,
    input  wire rdm_pkg::rdm_write_t         frame_word,
    output logic [1:0]                       mode_field,
    output logic [rdm_pkg::NUM_CH-1:0]       channel_on,
    output rdm_pkg::rdm_cfg_t                cfg,
    output logic [rdm_pkg::NUM_CH-1:0]       channel_error_bits,
    output logic [rdm_pkg::NUM_CH-1:0]       output_status_monitor_bits,
    output logic                             vs_uv_flag,
    output logic                             vdd_lowpower_flag,
    output logic                             transmission_error_flag,
    output logic                             diag_enable,
    output logic                             spi_enable,
    output logic                             power_on,
    output logic                             write_refused
);
    import rdm_pkg::*;

    // ************************************************************
    // link domain capture
    // ************************************************************
    // the link clock may stop after the frame, so the word and kind
    // are latched on the last edge and held until the next frame
    rdm_write_t link_word;
    rdm_frame_t link_kind;
    logic       link_toggle;

    always_ff @(posedge link_clock or posedge rst) begin
        if (rst) begin
            link_word   <= WRITE_RESET;
            link_kind   <= '0;
            link_toggle <= 1'b0;
        end else if (frame_end) begin
            link_word   <= frame_word;
            link_kind   <= frame_kind;
            link_toggle <= ~link_toggle;
        end
    end

    // ************************************************************
    // synchronisers
    // ************************************************************
    localparam int PIN_W = 1 + NUM_IN + $bits(rdm_supply_t) + NUM_CH;

    logic [PIN_W-1:0]  pin_meta;
    logic [PIN_W-1:0]  pin_sync;
    logic              tog_meta;
    logic              tog_sync;
    logic              tog_seen;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pin_meta <= '0;
            pin_sync <= '0;
        end else if (clock_enable) begin
            pin_meta <= {wake_pin, direct_input_pins, supply_levels,
                         channel_fault};                     // [RULE_25]
            pin_sync <= pin_meta;                            // [RULE_25]
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tog_meta <= 1'b0;
            tog_sync <= 1'b0;
            tog_seen <= 1'b0;
        end else if (clock_enable) begin
            tog_meta <= link_toggle;
            tog_sync <= tog_meta;
            tog_seen <= tog_sync;
        end
    end

    logic              wake_s;
    logic [NUM_IN-1:0] in_s;
    rdm_supply_t       sup;
    logic [NUM_CH-1:0] fault_s;

    assign {wake_s, in_s, sup, fault_s} = pin_sync;

    // ************************************************************
    // frame events in the system domain
    // ************************************************************
    // word and kind are stable here: they changed on the same edge as the toggle
    // and the toggle needed two cycles to cross
    logic frame_evt;
    logic diag_read_evt;
    logic write_evt;
    logic writable;
    logic write_accept;
    logic soft_cmd;

    rdm_state_t state;
    rdm_state_t next_state;

    assign frame_evt     = clock_enable & (tog_sync ^ tog_seen);
    assign diag_read_evt = frame_evt & link_kind.is_diag_read;
    assign write_evt     = frame_evt & link_kind.is_write;
    assign writable      = sup.vdd_ok &
                           ((state == ST_IDLE) | (state == ST_ACTIVE));
    assign write_accept  = write_evt & writable;             // [RULE_12]
    assign soft_cmd      = write_accept & link_word.soft_reset_bit;

    // ************************************************************
    // mode selection
    // ************************************************************
    logic any_in;
    logic any_sw;
    logic next_power_on;

    assign any_in = |in_s;
    assign any_sw = |cfg.channel_switch_bits;
    assign next_power_on = (sup.vs_above_op |
                            (sup.vdd_ok & ~sup.vdd_in_lop)) &
                           (any_in | wake_s);                // [RULE_23]

    always_comb begin
        next_state = state;
        if (!next_power_on) begin
            next_state = ST_SLEEP;                           // [RULE_01]
        end else if (!wake_s) begin
            // wake low: an input request can only mean limp home
            next_state = any_in ? ST_LIMP : ST_SLEEP;        // [RULE_11]
        end else begin
            case (state)
                ST_ACTIVE: begin
                    if (!sup.vdd_ok && !any_in) begin
                        next_state = ST_IDLE;                // [RULE_09]
                    end else if (cfg.stay_active_bit) begin
                        next_state = ST_ACTIVE;              // [RULE_08]
                    end else if (any_in || any_sw) begin
                        next_state = ST_ACTIVE;
                    end else begin
                        next_state = ST_IDLE;                // [RULE_07]
                    end
                end
                default: begin
                    // input alone suffices, whatever the maps hold
                    if (any_in || any_sw) begin
                        next_state = ST_ACTIVE;   // [RULE_02] [RULE_06]
                    end else begin
                        next_state = ST_IDLE;                // [RULE_10]
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state <= ST_SLEEP;
        end else if (clock_enable) begin
            state <= next_state;                             // [RULE_01]
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mode_field  <= MODE_SLEEP;
            diag_enable <= 1'b0;
            spi_enable  <= 1'b0;
            power_on    <= 1'b0;
        end else if (clock_enable) begin
            power_on    <= next_power_on;
            // diagnosis runs only where channels can be driven
            diag_enable <= (next_state == ST_ACTIVE) |
                           (next_state == ST_LIMP);          // [RULE_04]
            spi_enable  <= sup.vdd_ok & (next_state != ST_SLEEP);
            case (next_state)
                ST_IDLE:   mode_field <= MODE_IDLE;
                ST_ACTIVE: mode_field <= MODE_ACTIVE;
                ST_LIMP:   mode_field <= MODE_LIMP;          // [RULE_13]
                default:   mode_field <= MODE_SLEEP;
            endcase
        end
    end

    // ************************************************************
    // configuration registers
    // ************************************************************
    logic reg_reset;

    // limp home and sleep keep the registers at default as well
    assign reg_reset = ~sup.vdd_ok | ~wake_s | soft_cmd |
                       (state == ST_SLEEP) |
                       (state == ST_LIMP);          // [RULE_16] [RULE_19]

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cfg <= CFG_RESET;
        end else if (clock_enable) begin
            if (reg_reset) begin
                cfg <= CFG_RESET;          // [RULE_03] [RULE_15] [RULE_21]
            end else if (write_accept) begin
                cfg <= link_word.cfg;                        // [RULE_04]
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            write_refused <= 1'b0;
        end else if (clock_enable) begin
            write_refused <= write_evt & ~writable;          // [RULE_12]
        end
    end

    // ************************************************************
    // channel drive
    // ************************************************************
    logic [NUM_CH-1:0] map_req;
    logic [NUM_CH-1:0] limp_req;
    logic [NUM_CH-1:0] next_channel_on;

    assign map_req  = (in_s[0] ? cfg.input_map_a : CH_NONE) |
                      (in_s[1] ? cfg.input_map_b : CH_NONE);
    // limp home ignores stored maps and uses the fixed tie of each pin
    assign limp_req = ((in_s[0] ? MAP_A_RST : CH_NONE) |
                       (in_s[1] ? MAP_B_RST : CH_NONE)) & LIMP_MASK;

    always_comb begin
        next_channel_on = CH_NONE;
        case (state)
            ST_ACTIVE: begin
                next_channel_on = cfg.channel_switch_bits | map_req;
            end
            ST_LIMP: begin
                next_channel_on = limp_req;       // [RULE_11] [RULE_17]
            end
            default: begin
                next_channel_on = CH_NONE;        // [RULE_03] [RULE_04]
            end
        endcase
        // vs undervoltage drops every channel until vs returns
        if (sup.vs_below_uv) begin
            next_channel_on = CH_NONE;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            channel_on                 <= CH_NONE;
            output_status_monitor_bits <= CH_NONE;
        end else if (clock_enable) begin
            channel_on                 <= next_channel_on;
            output_status_monitor_bits <= channel_on;        // [RULE_15]
        end
    end

    // ************************************************************
    // channel error bits
    // ************************************************************
    // sticky; set wins over a readout clear; a soft reset never
    // touches them and idle neither sets nor clears them
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            channel_error_bits <= CH_NONE;
        end else if (clock_enable) begin
            if (state == ST_SLEEP) begin
                channel_error_bits <= CH_NONE;
            end else if (diag_enable) begin
                channel_error_bits <= (diag_read_evt ? CH_NONE :
                                       channel_error_bits) |
                                      (fault_s & channel_on); // [RULE_15]
            end else begin
                channel_error_bits <= channel_error_bits; // [RULE_05] [RULE_20]
            end
        end
    end

    // ************************************************************
    // supply flags
    // ************************************************************
    logic vs_clear;
    logic vdd_clear;

    assign vs_clear  = (diag_read_evt & sup.vs_above_op) | soft_cmd;
    assign vdd_clear = (diag_read_evt & ~sup.vdd_in_lop) | soft_cmd;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            vs_uv_flag <= 1'b0;
        end else if (clock_enable) begin
            if (state == ST_SLEEP) begin
                vs_uv_flag <= 1'b0;
            end else if (state == ST_LIMP) begin
                vs_uv_flag <= 1'b1;                          // [RULE_13]
            end else begin
                vs_uv_flag <= sup.vs_below_uv |
                              (vs_uv_flag & ~vs_clear); // [RULE_20] [RULE_22]
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            vdd_lowpower_flag <= 1'b0;
        end else if (clock_enable) begin
            if (state == ST_SLEEP) begin
                vdd_lowpower_flag <= 1'b0;
            end else if (state == ST_LIMP) begin
                vdd_lowpower_flag <= 1'b1;                   // [RULE_13]
            end else begin
                vdd_lowpower_flag <= sup.vdd_in_lop |
                                     (vdd_lowpower_flag & ~vdd_clear); // [RULE_24]
            end
        end
    end

    // ************************************************************
    // transmission error
    // ************************************************************
    // the pending mark survives until a frame consumes it; a new limp
    // entry in the same cycle as that frame keeps it armed
    logic ter_pending;
    logic limp_entry;

    assign limp_entry = (state != ST_LIMP) & (next_state == ST_LIMP);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ter_pending <= 1'b0;
        end else if (clock_enable) begin
            ter_pending <= limp_entry |
                           (ter_pending & ~frame_evt);       // [RULE_14]
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            transmission_error_flag <= 1'b0;
        end else if (clock_enable) begin
            if (state == ST_SLEEP) begin
                transmission_error_flag <= 1'b0;
            end else if (frame_evt) begin
                // responses around a limp transition are not defined
                transmission_error_flag <= link_kind.is_bad |
                                           ter_pending; // [RULE_14] [RULE_18]
            end
        end
    end

endmodule

// ==== verif/rdm_host_model.sv ====
// Purpose: host side of the link; hands over one finished frame.
// Assumes: link clock runs only while a frame is handed over.
// Notes:   released lines show the inverse of the last value.
`timescale 1ns/1ps
module rdm_host_model
    import rdm_pkg::*;
(
    output logic       link_clock,
    output logic       frame_end,
    output rdm_frame_t frame_kind,
    output rdm_write_t frame_word
);
    initial begin
        link_clock = 1'b0;
        frame_end  = 1'b0;
        frame_kind = '0;
        frame_word = '0;
    end
    // called only away from limp transitions
    task automatic send(input rdm_frame_t k, input rdm_write_t w);
        frame_kind = k;
        frame_word = w;
        frame_end  = 1'b1;
        #7.5 link_clock = 1'b1;
        #7.5 link_clock = 1'b0;
        frame_end  = 1'b0;
        frame_kind = ~k;
        frame_word = ~w;
    endtask
endmodule

// ==== verif/rdm_mode_controller_assertions.sv ====
// Purpose: mode, channel and register checks at the controller ports.
// Assumes: system clock domain only.
// Notes:   pin sync costs two edges, so requests are held four.
`timescale 1ns/1ps
module rdm_mode_controller_assertions
    import rdm_pkg::*;
(
    input wire logic              clock,
    input wire logic              rst,
    input wire logic              clock_enable,
    input wire logic              wake_pin,
    input wire logic [NUM_IN-1:0] direct_input_pins,
    input wire rdm_supply_t       supply_levels,
    input wire logic [1:0]        mode_field,
    input wire logic [NUM_CH-1:0] channel_on,
    input wire rdm_cfg_t          cfg,
    input wire logic              vs_uv_flag,
    input wire logic              vdd_lowpower_flag,
    input wire logic              diag_enable
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    wire logic up;
    wire logic in_any;
    assign up = clock_enable && supply_levels.vdd_ok;
    assign in_any = |direct_input_pins;
    sequence s_wake_req;
        (up && supply_levels.vs_above_op && wake_pin && in_any)[*4];
    endsequence
    sequence s_limp_req;
        (up && supply_levels.vs_above_op && !wake_pin && in_any)[*4];
    endsequence
    sequence s_all_low;
        (up && wake_pin && !in_any && !cfg.stay_active_bit
         && cfg.channel_switch_bits == CH_NONE)[*4];
    endsequence
    sequence s_held(logic [1:0] m);
        mode_field == m ##1 mode_field == m;
    endsequence
    a_wake_active: assert property (s_wake_req |-> mode_field == MODE_ACTIVE)
        else $error("wake and input held but not active");
    a_limp_entry: assert property (s_limp_req |-> mode_field == MODE_LIMP)
        else $error("input without wake but not limp home");
    a_idle_return: assert property (s_all_low |-> mode_field == MODE_IDLE)
        else $error("no request left but not idle");
    a_stay_active: assert property ((wake_pin && up)[*3] ##0
        (mode_field == MODE_ACTIVE && cfg.stay_active_bit)
        ##1 cfg.stay_active_bit |-> mode_field == MODE_ACTIVE)
        else $error("left active with stay bit set");
    a_vdd_idle: assert property ((clock_enable && !in_any
        && !supply_levels.vdd_ok)[*4] |-> mode_field != MODE_ACTIVE)
        else $error("active kept through vdd undervoltage");
    a_idle_chans: assert property (s_held(MODE_IDLE)
        |-> channel_on == CH_NONE && !diag_enable)
        else $error("channel or diagnosis live in idle");
    a_sleep_reset: assert property (s_held(MODE_SLEEP)
        |-> channel_on == CH_NONE && cfg == CFG_RESET)
        else $error("sleep with channel on or live registers");
    a_limp_chans: assert property (s_held(MODE_LIMP)
        |-> (channel_on & ~LIMP_MASK) == CH_NONE)
        else $error("limp home drives a forbidden channel");
    a_limp_flags: assert property (s_held(MODE_LIMP)
        |-> vs_uv_flag && vdd_lowpower_flag
        && !cfg.openload_on_enable && !cfg.openload_off_enable)
        else $error("limp home flags or open-load bits wrong");
    a_limp_regs: assert property (s_held(MODE_LIMP) |-> cfg == CFG_RESET)
        else $error("limp home registers not at default");
endmodule
bind rdm_mode_controller rdm_mode_controller_assertions chk_u (
    .clock, .rst, .clock_enable, .wake_pin, .direct_input_pins,
    .supply_levels, .mode_field, .channel_on, .cfg, .vs_uv_flag,
    .vdd_lowpower_flag, .diag_enable);

// ==== verif/rdm_mode_controller_tb.sv ====
// Purpose: self-checking bench of the mode controller.
// Assumes: frames come from the host model, pins from the bench.
// Notes:   waits are bounded; expectations come from the package.
`timescale 1ns/1ps
module rdm_mode_controller_tb;
    import rdm_pkg::*;
    localparam rdm_frame_t WR = '{1'b1, 1'b0, 1'b0};
    localparam rdm_frame_t RD = '{1'b0, 1'b1, 1'b0};
    logic clock = 1'b0, rst = 1'b1, clock_enable = 1'b1, wake_pin = 1'b0;
    logic [NUM_IN-1:0] direct_input_pins = '0;
    rdm_supply_t supply_levels = '{1'b1, 1'b0, 1'b0, 1'b1};
    logic [NUM_CH-1:0] channel_fault = '0, channel_on;
    logic [NUM_CH-1:0] channel_error_bits, output_status_monitor_bits;
    logic link_clock, frame_end, vs_uv_flag, vdd_lowpower_flag;
    logic transmission_error_flag, diag_enable, spi_enable, power_on;
    logic write_refused, seen;
    logic [1:0] mode_field;
    rdm_frame_t frame_kind;
    rdm_write_t frame_word;
    rdm_cfg_t cfg, c;
    int fails = 0, cmp_count = 0;
    always #20 clock = ~clock;
    rdm_host_model host_u (.link_clock, .frame_end, .frame_kind,
        .frame_word);
    rdm_mode_controller dut_u (.clock, .rst, .clock_enable, .wake_pin,
        .direct_input_pins, .supply_levels, .channel_fault, .link_clock,
        .frame_end, .frame_kind, .frame_word, .mode_field, .channel_on,
        .cfg, .channel_error_bits, .output_status_monitor_bits,
        .vs_uv_flag, .vdd_lowpower_flag, .transmission_error_flag,
        .diag_enable, .spi_enable, .power_on, .write_refused);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic wait_mode(input logic [1:0] m);
        for (int n = 0; n < 20 && mode_field !== m; n++) tick(1);
        chk(mode_field, m);
    endtask
    task automatic put(input rdm_cfg_t w, input logic sr);
        host_u.send(WR, '{cfg: w, soft_reset_bit: sr});
        tick(8);
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ********************************
    // scenarios
    // ********************************
    task automatic t_pins;
        @(posedge clock);
        wake_pin <= 1'b1;
        direct_input_pins <= 2'b01;
        wait_mode(MODE_ACTIVE);
        tick(2);
        chk(channel_on, MAP_A_RST);
        chk(output_status_monitor_bits, MAP_A_RST);
        chk({power_on, spi_enable}, 2'b11);
        @(posedge clock);
        channel_fault <= 8'h04;
        tick(4);
        chk(channel_error_bits, 8'h04);
        @(posedge clock);
        channel_fault <= 8'h00;
        direct_input_pins <= 2'b00;
        wait_mode(MODE_IDLE);
        tick(2);
        chk({channel_on, diag_enable}, 9'h000);
        chk(channel_error_bits, 8'h04);
        $display("pin test done");
    endtask
    task automatic t_spi;
        @(posedge clock);
        supply_levels.vs_below_uv <= 1'b1;
        tick(5);
        @(posedge clock);
        supply_levels.vs_below_uv <= 1'b0;
        tick(4);
        chk(vs_uv_flag, 1'b1);
        c = CFG_RESET;
        c.channel_switch_bits = 8'h01;
        put(c, 1'b0);
        wait_mode(MODE_ACTIVE);
        tick(2);
        chk(channel_on, 8'h01);
        c.channel_switch_bits = CH_NONE;
        c.stay_active_bit = 1'b1;
        put(c, 1'b0);
        tick(10);
        chk(mode_field, MODE_ACTIVE);
        put(c, 1'b1);
        chk(cfg, CFG_RESET);
        chk(vs_uv_flag, 1'b0);
        chk(channel_error_bits, 8'h04);
        wait_mode(MODE_IDLE);
        $display("register test done");
    endtask
    task automatic t_limp;
        @(posedge clock);
        wake_pin <= 1'b0;
        direct_input_pins <= 2'b10;
        wait_mode(MODE_LIMP);
        tick(2);
        chk(channel_on, MAP_B_RST);
        chk({vs_uv_flag, vdd_lowpower_flag}, 2'b11);
        c = CFG_RESET;
        c.channel_switch_bits = 8'hFF;
        c.openload_on_enable = 1'b1;
        host_u.send(WR, '{cfg: c, soft_reset_bit: 1'b0});
        seen = 1'b0;
        repeat (10) begin
            tick(1);
            seen = seen | write_refused;
        end
        chk(seen, 1'b1);
        chk(cfg, CFG_RESET);
        chk(transmission_error_flag, 1'b1);
        host_u.send(RD, WRITE_RESET);
        tick(8);
        chk(transmission_error_flag, 1'b0);
        chk(channel_error_bits, 8'h00);
        @(posedge clock);
        direct_input_pins <= 2'b00;
        wait_mode(MODE_SLEEP);
        $display("limp test done");
    endtask
    initial begin
        #100000;
        fails++;
        stop_test();
    end
    initial begin
        tick(5);
        chk(mode_field, MODE_SLEEP);
        chk(cfg, CFG_RESET);
        @(posedge clock);
        rst <= 1'b0;
        tick(6);
        chk(mode_field, MODE_SLEEP);
        t_pins();
        t_spi();
        t_limp();
        stop_test();
    end
endmodule
